// *** shared/cit_pkg.sv ***
/*
 * types and constants shared by the instruction timing sequencer:
 * the decoded timing record and the byte and cycle counts it holds.
 * assumes one system clock; every cycle count is in cycles of that clock.
 */
package cit_pkg;

    // ------------------------------------------------------------
    // instruction lengths in program bytes
    // ------------------------------------------------------------
    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;

    // ------------------------------------------------------------
    // execution times in system clock cycles
    // ------------------------------------------------------------
    localparam logic [3:0] CYC_1 = 4'h1;
    localparam logic [3:0] CYC_2 = 4'h2;
    localparam logic [3:0] CYC_3 = 4'h3;
    localparam logic [3:0] CYC_4 = 4'h4;
    localparam logic [3:0] CYC_8 = 4'h8;

    // extra cycle a conditional branch spends when the jump is taken
    localparam logic [3:0] CYC_TAKEN_EXTRA = 4'h1;

    // ------------------------------------------------------------
    // decoded timing record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cycles;
        logic       cond_branch;
        logic       known;
    } cit_timing_type;

    localparam cit_timing_type TIMING_RESET = '{
        len: 2'h0, cycles: 4'h0, cond_branch: 1'b0, known: 1'b0
    };

endpackage

// *** rtl/cit_sequencer.sv ***
/*
 * instruction length decode and execution timing sequencer.
 * an opcode offered on the fetch port is decoded into its byte
 * length and cycle count; the fetch port then stays closed until
 * that many system clock cycles have passed.
 * assumes the fetch source holds opcode and branch_taken stable
 * while fetch_valid is high, and resolves branch_taken for a
 * conditional branch by the cycle the opcode is offered.
 */
`timescale 1ns/100ps

module cit_sequencer
    import cit_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic           rstn,
    input  wire logic           fetch_valid,
    input  wire logic [7:0]     fetch_opcode,
    input  wire logic           branch_taken,
    output wire logic           fetch_ready,
    output wire logic           exec_busy,
    output logic                exec_done,
    output cit_timing_type      instr_timing
);

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    function automatic cit_timing_type mk(
        input logic [1:0] len,
        input logic [3:0] cyc
    );
        cit_timing_type t;
        t.len         = len;
        t.cycles      = cyc;
        t.cond_branch = 1'b0;
        t.known       = 1'b1;
        return t;
    endfunction

    // unlisted opcodes (program branching and the rest) come back
    // as one byte, one cycle with known low so the core can flag them
    function automatic cit_timing_type cit_decode(input logic [7:0] op);
        cit_timing_type t;
        t = TIMING_RESET;
        t.len    = LEN_1;
        t.cycles = CYC_1;
        casez (op)
            8'h00, 8'hA5:
                t = mk(LEN_1, CYC_1);
            8'hA3, 8'hD4:
                t = mk(LEN_1, CYC_1);
            8'hA4:
                t = mk(LEN_1, CYC_4);
            8'h84:
                t = mk(LEN_1, CYC_8);
            8'h03, 8'h13, 8'h23, 8'h33,
            8'hC4, 8'hE4, 8'hF4:
                t = mk(LEN_1, CYC_1);
            8'h04, 8'h14:
                t = mk(LEN_1, CYC_1);
            8'hB3, 8'hC3, 8'hD3:
                t = mk(LEN_1, CYC_1);
            8'hB2, 8'hC2, 8'hD2:
                t = mk(LEN_2, CYC_2);
            8'h42, 8'h52, 8'h62:
                t = mk(LEN_2, CYC_2);
            8'h43, 8'h53, 8'h63:
                t = mk(LEN_3, CYC_3);
            8'h40, 8'h50: begin
                t = mk(LEN_2, CYC_2);
                t.cond_branch = 1'b1;
            end
            8'h90:
                t = mk(LEN_3, CYC_3);
            8'h83, 8'h93:
                t = mk(LEN_1, CYC_3);
            8'hE0, 8'hE2, 8'hE3,
            8'hF0, 8'hF2, 8'hF3:
                t = mk(LEN_1, CYC_3);
            8'hC0, 8'hD0:
                t = mk(LEN_2, CYC_2);
            8'hD6, 8'hD7:
                t = mk(LEN_1, CYC_2);
            8'h85, 8'h75:
                t = mk(LEN_3, CYC_3);
            8'hF6, 8'hF7:
                t = mk(LEN_1, CYC_2);
            8'h76, 8'h77, 8'h86, 8'h87,
            8'hA6, 8'hA7:
                t = mk(LEN_2, CYC_2);
            8'b1010_1???:
                t = mk(LEN_2, CYC_2);
            8'b0111_1???, 8'b1000_1???:
                t = mk(LEN_2, CYC_2);
            8'b1100_1???, 8'b1110_1???,
            8'b1111_1???:
                t = mk(LEN_1, CYC_1);
            8'hC5, 8'hE5, 8'hF5:
                t = mk(LEN_2, CYC_2);
            8'hC6, 8'hC7, 8'hE6, 8'hE7:
                t = mk(LEN_1, CYC_2);
            8'b0???0100, 8'h94:
                t = mk(LEN_2, CYC_2);
            8'b0???0101, 8'h95:
                t = mk(LEN_2, CYC_2);
            8'b0???011?, 8'b1001011?:
                t = mk(LEN_1, CYC_2);
            8'b0???_1???, 8'b1001_1???:
                t = mk(LEN_1, CYC_1);
            default:
                t.known = 1'b0;
        endcase
        return t;
    endfunction

    // ------------------------------------------------------------
    // decode and effective cycle count
    // ------------------------------------------------------------
    typedef enum logic { ST_IDLE, ST_EXEC } cit_state_type;

    cit_state_type  state;
    logic [3:0]     left;
    cit_timing_type dec;
    logic [3:0]     dec_cycles;
    logic [3:0]     eff_cycles;
    logic           accept;
    logic           next_done;
    logic           last_exec;

    assign dec        = cit_decode(fetch_opcode);
    assign dec_cycles = dec.cycles;

    // a taken branch runs one cycle longer than an untaken one
    assign eff_cycles = (dec.cond_branch && branch_taken)
                        ? 4'(dec_cycles + CYC_TAKEN_EXTRA)
                        : dec_cycles;

    // fetch is closed while an instruction still owns cycles
    assign fetch_ready = (state == ST_IDLE);
    assign exec_busy   = (state == ST_EXEC);
    assign accept      = fetch_valid && fetch_ready;
    assign last_exec   = exec_busy && (left == CYC_1);
    assign next_done   = (accept && eff_cycles == CYC_1) || last_exec;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // the cycle of acceptance is the first execution cycle, so the
    // counter holds what remains after it
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state        <= ST_IDLE;
            left         <= 4'h0;
            exec_done    <= 1'b0;
            instr_timing <= TIMING_RESET;
        end else begin
            exec_done <= next_done;
            unique case (state)
                ST_IDLE: begin
                    if (accept) begin
                        instr_timing        <= dec;
                        instr_timing.cycles <= eff_cycles;
                        left  <= 4'(eff_cycles - CYC_1);
                        state <= (eff_cycles == CYC_1) ? ST_IDLE : ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    left <= 4'(left - CYC_1);
                    if (left == CYC_1) begin
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic [3:0] op_hi;
    logic       alu_row;
    logic       alu_rn;
    logic       alu_ind;
    logic       alu_imm;
    logic       xdata_op;
    logic       acc_only;

    assign op_hi    = fetch_opcode[7:4];
    assign alu_row  = (op_hi inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9});
    assign alu_rn   = alu_row && fetch_opcode[3];
    assign alu_ind  = alu_row && (fetch_opcode[3:1] == 3'h3);
    assign alu_imm  = alu_row && (fetch_opcode[3:0] == 4'h4);
    assign xdata_op = (fetch_opcode inside {8'hE0, 8'hE2, 8'hE3,
                                            8'hF0, 8'hF2, 8'hF3});
    assign acc_only = (fetch_opcode inside {8'h03, 8'h13, 8'h23, 8'h33,
                                            8'hC4, 8'hE4, 8'hF4});

    chk_clock_step: assert property (
        exec_busy |=> left == 4'($past(left) - CYC_1))
        else $error("counter did not step by one clock");

    chk_bytes_bound: assert property (
        accept && dec.known |-> dec_cycles >= {2'h0, dec.len})
        else $error("instruction faster than its byte count");

    chk_branch_extra: assert property (
        accept && dec.cond_branch
        |=> instr_timing.cycles == 4'($past(dec_cycles) + {3'h0, $past(branch_taken)}))
        else $error("branch cycle count wrong for taken state");

    chk_alu_reg_one: assert property (
        accept && alu_rn |=> fetch_ready && exec_done
                             && instr_timing.len == LEN_1)
        else $error("register alu op not one cycle");

    chk_alu_ind_two: assert property (
        accept && alu_ind |=> !fetch_ready ##1 fetch_ready && exec_done)
        else $error("indirect alu op not two cycles");

    chk_alu_imm_two: assert property (
        accept && alu_imm |=> !fetch_ready && instr_timing.len == LEN_2
                              ##1 fetch_ready)
        else $error("immediate alu op not two cycles");

    chk_dir_imm_three: assert property (
        accept && (fetch_opcode inside {8'h43, 8'h53, 8'h63})
        |=> !fetch_ready [*2] ##1 fetch_ready)
        else $error("direct immediate logic op not three cycles");

    chk_acc_only_one: assert property (
        accept && acc_only |=> fetch_ready && exec_done)
        else $error("accumulator op not one cycle");

    chk_xdata_three: assert property (
        accept && xdata_op |=> !fetch_ready [*2] ##1 fetch_ready)
        else $error("external data move not three cycles");

    chk_div_hold: assert property (
        accept && fetch_opcode == 8'h84
        |=> !fetch_ready [*7] ##1 fetch_ready && exec_done)
        else $error("fetch reopened before divide finished");

    chk_done_ready: assert property (
        exec_done |-> fetch_ready && !$past(exec_busy && left > CYC_1))
        else $error("done pulse while instruction still running");

    cov_back_to_back: cover property (
        accept && eff_cycles == CYC_1 ##1 accept);

    cov_branch_taken: cover property (
        accept && dec.cond_branch && branch_taken);

    cov_branch_untaken: cover property (
        accept && dec.cond_branch && !branch_taken);

    cov_unknown_op: cover property (accept && !dec.known);

endmodule // cit_sequencer

// *** dv/testbench.sv ***
/*
 * self-checking bench for the instruction timing sequencer: drives the
 * fetch port by hand and times every answer in system clock cycles.
 * assumes the design package is compiled first; no partner model.
 */
`timescale 1ns/100ps

module testbench
    import cit_pkg::*;
;

    logic           sys_clk;
    logic           rstn;
    logic           fetch_valid;
    logic [7:0]     fetch_opcode;
    logic           branch_taken;
    logic           fetch_ready;
    logic           exec_busy;
    logic           exec_done;
    cit_timing_type instr_timing;
    int             n_mismatch;
    int             comparisons;

`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
end

    always #5 sys_clk = ~sys_clk;

    cit_sequencer u_cit_sequencer (
        .sys_clk      (sys_clk),
        .rstn         (rstn),
        .fetch_valid  (fetch_valid),
        .fetch_opcode (fetch_opcode),
        .branch_taken (branch_taken),
        .fetch_ready  (fetch_ready),
        .exec_busy    (exec_busy),
        .exec_done    (exec_done),
        .instr_timing (instr_timing)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic step();
        @(posedge sys_clk);
        #1;
    endtask

    task automatic apply_reset(input int n);
        rstn = 1'b0;
        repeat (n) step();
        `CHK({fetch_ready, exec_busy, exec_done, instr_timing}, {3'b100, TIMING_RESET})
        rstn = 1'b1;
        step();
        `CHK({fetch_ready, exec_busy, exec_done, instr_timing}, {3'b100, TIMING_RESET})
    endtask

    // flags: {branch taken, known, keep fetch_valid up for a back-to-back take}
    task automatic run_op(input logic [7:0] op, input logic [1:0] len,
                          input logic [3:0] cyc, input logic [2:0] flags);
        int             i;
        cit_timing_type exp_t;
        exp_t = '{len: len, cycles: cyc, cond_branch: (op == 8'h40 || op == 8'h50),
                  known: flags[1]};
        i = 0;
        while (fetch_ready !== 1'b1 && i < 16) begin
            step();
            i++;
        end
        if (i == 16) begin
            n_mismatch++;
            tally_and_finish();
        end
        fetch_opcode = op;
        branch_taken = flags[2];
        fetch_valid  = 1'b1;
        step();
        if (!flags[0]) begin
            fetch_valid = 1'b0;
        end
        `CHK(instr_timing, exp_t)
        // a held request with the old opcode must be refused until the count ends
        for (i = 1; i < cyc; i++) begin
            `CHK({fetch_ready, exec_busy, exec_done}, 3'b010)
            step();
        end
        `CHK({fetch_ready, exec_busy, exec_done, instr_timing}, {3'b101, exp_t})
        // a released request lets one edge pass, so the next call never raises
        // valid in the step that lowered it; done must have fallen by then
        if (!flags[0]) begin
            step();
            `CHK({fetch_ready, exec_busy, exec_done}, 3'b100)
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic arith_logic();
        run_op(8'h28, LEN_1, CYC_1, 3'h2);
        run_op(8'h39, LEN_1, CYC_1, 3'h2);
        run_op(8'h9A, LEN_1, CYC_1, 3'h2);
        run_op(8'h26, LEN_1, CYC_2, 3'h2);
        run_op(8'h57, LEN_1, CYC_2, 3'h2);
        run_op(8'h24, LEN_2, CYC_2, 3'h2);
        run_op(8'h34, LEN_2, CYC_2, 3'h2);
        run_op(8'h53, LEN_3, CYC_3, 3'h2);
        run_op(8'h43, LEN_3, CYC_3, 3'h2);
        run_op(8'h63, LEN_3, CYC_3, 3'h2);
        run_op(8'hA4, LEN_1, CYC_4, 3'h2);
        run_op(8'h84, LEN_1, CYC_8, 3'h2);
    endtask

    // accumulator-only ops taken on every cycle with valid held, then an unknown op and two three-cycle moves, the last with valid dropped
    task automatic accu_back_to_back();
        run_op(8'hE4, LEN_1, CYC_1, 3'h3);
        run_op(8'hF4, LEN_1, CYC_1, 3'h3);
        run_op(8'h23, LEN_1, CYC_1, 3'h3);
        run_op(8'h33, LEN_1, CYC_1, 3'h3);
        run_op(8'h03, LEN_1, CYC_1, 3'h3);
        run_op(8'h13, LEN_1, CYC_1, 3'h3);
        run_op(8'hC4, LEN_1, CYC_1, 3'h7);
        run_op(8'h11, LEN_1, CYC_1, 3'h1);
        run_op(8'h85, LEN_3, CYC_3, 3'h3);
        run_op(8'hE0, LEN_1, CYC_3, 3'h2);
    endtask

    task automatic transfer();
        run_op(8'hA8, LEN_2, CYC_2, 3'h2);
        run_op(8'hF6, LEN_1, CYC_2, 3'h2);
        run_op(8'h90, LEN_3, CYC_3, 3'h2);
        run_op(8'h93, LEN_1, CYC_3, 3'h2);
        run_op(8'h83, LEN_1, CYC_3, 3'h2);
        run_op(8'hE2, LEN_1, CYC_3, 3'h2);
        run_op(8'hF2, LEN_1, CYC_3, 3'h2);
        run_op(8'hF0, LEN_1, CYC_3, 3'h2);
        run_op(8'hC0, LEN_2, CYC_2, 3'h2);
        run_op(8'hD0, LEN_2, CYC_2, 3'h2);
        run_op(8'hD6, LEN_1, CYC_2, 3'h2);
    endtask

    task automatic branches();
        run_op(8'h40, LEN_2, CYC_2, 3'h3);
        run_op(8'h40, LEN_2, CYC_3, 3'h6);
        run_op(8'h50, LEN_2, CYC_3, 3'h6);
        run_op(8'h50, LEN_2, CYC_2, 3'h2);
    endtask

    task automatic reset_mid_run();
        fetch_opcode = 8'h84;
        fetch_valid  = 1'b1;
        step();
        fetch_valid  = 1'b0;
        step();
        `CHK(fetch_ready, 1'b0)
        apply_reset(1);
        run_op(8'h28, LEN_1, CYC_1, 3'h2);
    endtask

    initial begin
        sys_clk      = 1'b0;
        rstn         = 1'b0;
        fetch_valid  = 1'b0;
        fetch_opcode = 8'h00;
        branch_taken = 1'b0;
        n_mismatch   = 0;
        comparisons  = 0;
        apply_reset(4);
        arith_logic();
        accu_back_to_back();
        transfer();
        branches();
        reset_mid_run();
        tally_and_finish();
    end

endmodule // testbench
